// ===== hdl/txfe_control.sv
// transmit front-end control outputs with their serial register file
//
// What the document asks of this block, its host and the parts it drives
// [RULE_01] general output pin follows the stored general output bit
// [RULE_02] host writes the output bit high for transmit, low for receive
// [RULE_03] output invert bit, reset clear, complements the general output pin
// [RULE_04] amplifier invert bit drives amplifier enable as complement of output
// [RULE_05] amplifier enable bit asserts amplifier enable during transmit while the amplifier invert bit is clear
// [RULE_06] both amplifier bits clear keep amplifier enable low
// [RULE_07] level DAC output forced to zero unless its enable bit is set
// [RULE_08] level DAC driven by 6-bit code, about 50 mV per step
// [RULE_09] level code gated to zero outside an active transmit cycle
// [RULE_10] external amplifier reaches full power within 5 us of enable
// [RULE_11] host sets antenna switch to transmit before internal amplifier on
// [RULE_12] 3-bit bias field selects one of eight internal amplifier powers
// [RULE_13] 32-bit identification split over two read-only 16-bit registers
// [RULE_14] outputs update the cycle after a write completes, glitch free
`default_nettype none
`include "txfe_defines.svh"
module txfe_control import txfe_pkg::*; #(
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_PART = 16'h0001, // arbitrary value
    parameter logic [6:0] ID_MAKER = 7'h01 // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic serEnableN,
    input wire logic serClk,
    input wire logic serDataIn,
    output logic serDataOut,
    output logic serDataOe,
    input wire logic txActive,
    output logic generalOutPin,
    output logic extAmpEnableOut,
    output logic [5:0] extAmpLevelDac,
    output logic [2:0] intAmpBiasSelect
);
    logic genOutBit_reg;
    logic outInvert_reg;
    logic ampInvert_reg;
    logic [5:0] levelCode_reg;
    logic [2:0] biasSel_reg;
    logic dacEnable_reg;
    logic ampEnable_reg;
    logic [4:0] regAddr;
    logic [15:0] wrData;
    logic wrStrobe;
    logic [15:0] rdData;
    logic pinLevel;

    function automatic logic [15:0] readBack(input logic [4:0] a);
        logic [15:0] v;
        v = `TXFE_REG_RESET;
        case (a)
            `TXFE_ADDR_CTRL2: begin
                v[`TXFE_GEN_OUT_BIT] = genOutBit_reg;
            end
            `TXFE_ADDR_CTRL3: begin
                v[`TXFE_AMP_INV_BIT] = ampInvert_reg;
                v[`TXFE_OUT_INV_BIT] = outInvert_reg;
                v[`TXFE_LVL_CODE_MSB:0] = levelCode_reg;
            end
            `TXFE_ADDR_CTRL5: begin
                v[`TXFE_BIAS_MSB:0] = biasSel_reg;
            end
            `TXFE_ADDR_CTRL11: begin
                v[`TXFE_DAC_EN_BIT] = dacEnable_reg;
                v[`TXFE_AMP_EN_BIT] = ampEnable_reg;
            end
            `TXFE_ADDR_ID_LOW: begin
                v = {ID_PART[3:0], `TXFE_ID_CONT_COUNT, ID_MAKER, 1'b1}; // RULE_13
            end
            `TXFE_ADDR_ID_HIGH: begin
                v = {ID_VERSION, ID_PART[15:4]}; // RULE_13
            end
            default: begin
                v = `TXFE_REG_RESET;
            end
        endcase
        return v;
    endfunction

    assign rdData = readBack(regAddr);

    txfe_serial_port port_u (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .serEnableN(serEnableN),
        .serClk(serClk),
        .serDataIn(serDataIn),
        .serDataOut(serDataOut),
        .serDataOe(serDataOe),
        .regAddr(regAddr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdData(rdData)
    );

    // only the documented bits are stored; the rest of each word reads zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            genOutBit_reg <= 1'b0;
            outInvert_reg <= 1'b0;
            ampInvert_reg <= 1'b0;
            levelCode_reg <= `TXFE_LVL_ZERO;
            biasSel_reg <= 3'h0;
            dacEnable_reg <= 1'b0;
            ampEnable_reg <= 1'b0;
        end else if (wrStrobe) begin
            case (regAddr)
                `TXFE_ADDR_CTRL2: begin
                    genOutBit_reg <= wrData[`TXFE_GEN_OUT_BIT]; // RULE_01
                end
                `TXFE_ADDR_CTRL3: begin
                    ampInvert_reg <= wrData[`TXFE_AMP_INV_BIT];
                    outInvert_reg <= wrData[`TXFE_OUT_INV_BIT]; // RULE_03
                    levelCode_reg <= wrData[`TXFE_LVL_CODE_MSB:0]; // RULE_08
                end
                `TXFE_ADDR_CTRL5: begin
                    biasSel_reg <= wrData[`TXFE_BIAS_MSB:0]; // RULE_12
                end
                `TXFE_ADDR_CTRL11: begin
                    dacEnable_reg <= wrData[`TXFE_DAC_EN_BIT];
                    ampEnable_reg <= wrData[`TXFE_AMP_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    assign pinLevel = genOutBit_reg ^ outInvert_reg; // RULE_03

    // registered pins: one cycle after the store, no decode glitches reach them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            generalOutPin <= 1'b0;
            extAmpEnableOut <= 1'b0;
            extAmpLevelDac <= `TXFE_LVL_ZERO;
            intAmpBiasSelect <= 3'h0;
        end else begin
            generalOutPin <= pinLevel; // RULE_01 RULE_14
            if (ampInvert_reg) begin
                // second antenna switch line, independent of transmit state
                extAmpEnableOut <= ~pinLevel; // RULE_04
            end else begin
                extAmpEnableOut <= ampEnable_reg & txActive; // RULE_05 RULE_06
            end
            if (dacEnable_reg && txActive) begin // RULE_07 RULE_09
                extAmpLevelDac <= levelCode_reg; // RULE_08
            end else begin
                extAmpLevelDac <= `TXFE_LVL_ZERO; // RULE_07 RULE_09
            end
            intAmpBiasSelect <= biasSel_reg; // RULE_12 RULE_14
        end
    end
endmodule
`default_nettype wire

// ===== hdl/txfe_defines.svh
// register addresses, field positions, reset values and frame counts
`ifndef TXFE_DEFINES_SVH
`define TXFE_DEFINES_SVH

`define TXFE_ADDR_CTRL2 5'h02
`define TXFE_ADDR_CTRL3 5'h03
`define TXFE_ADDR_CTRL5 5'h05
`define TXFE_ADDR_CTRL11 5'h0B
`define TXFE_ADDR_ID_LOW 5'h1E
`define TXFE_ADDR_ID_HIGH 5'h1F

`define TXFE_GEN_OUT_BIT 8
`define TXFE_OUT_INV_BIT 6
`define TXFE_AMP_INV_BIT 10
`define TXFE_LVL_CODE_MSB 5
`define TXFE_BIAS_MSB 2
`define TXFE_DAC_EN_BIT 7
`define TXFE_AMP_EN_BIT 6

`define TXFE_REG_RESET 16'h0000
`define TXFE_LVL_ZERO 6'h00
`define TXFE_ID_CONT_COUNT 4'h0

`define TXFE_HDR_LAST 5'h07
`define TXFE_HDR_BITS 5'h08
`define TXFE_FRAME_LAST 5'h17
`define TXFE_FRAME_BITS 5'h18
`define TXFE_PINS_IDLE 3'h4

`endif

// ===== hdl/txfe_pkg.sv
// types shared by the transmit front-end control block
`default_nettype none
package txfe_pkg;
    typedef enum logic [1:0] {
        TXFE_IDLE = 2'b00,
        TXFE_HEADER = 2'b01,
        TXFE_DATA = 2'b11
    } txfe_phase_t;
endpackage
`default_nettype wire

// ===== hdl/txfe_serial_port.sv
// serial control port slave: frame decode, write strobe, read shift-out
`default_nettype none
`include "txfe_defines.svh"
module txfe_serial_port import txfe_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic serEnableN,
    input wire logic serClk,
    input wire logic serDataIn,
    output logic serDataOut,
    output logic serDataOe,
    output logic [4:0] regAddr,
    output logic [15:0] wrData,
    output logic wrStrobe,
    input wire logic [15:0] rdData
);
    logic [2:0] pinsMeta_reg;
    logic [2:0] pinsSync_reg;
    logic clkLast_reg;
    txfe_phase_t phase_reg;
    logic [4:0] bitCnt_reg;
    logic [15:0] shiftIn_reg;
    logic isRead_reg;
    logic loadPending_reg;
    logic [14:0] shiftOut_reg;
    logic enN;
    logic sclk;
    logic din;
    logic rise;
    logic fall;

    assign enN = pinsSync_reg[2];
    assign sclk = pinsSync_reg[1];
    assign din = pinsSync_reg[0];
    assign rise = sclk & ~clkLast_reg;
    assign fall = ~sclk & clkLast_reg;

    // pins are asynchronous to sys_clk; edges are found after the second stage
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pinsMeta_reg <= `TXFE_PINS_IDLE;
            pinsSync_reg <= `TXFE_PINS_IDLE;
            clkLast_reg <= 1'b0;
        end else begin
            pinsMeta_reg <= {serEnableN, serClk, serDataIn};
            pinsSync_reg <= pinsMeta_reg;
            clkLast_reg <= pinsSync_reg[1];
        end
    end

    // frame: read flag, two spare bits, 5-bit address, 16 data bits, msb first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= TXFE_IDLE;
            bitCnt_reg <= 5'h00;
            shiftIn_reg <= `TXFE_REG_RESET;
            isRead_reg <= 1'b0;
            loadPending_reg <= 1'b0;
            regAddr <= 5'h00;
            wrData <= `TXFE_REG_RESET;
            wrStrobe <= 1'b0;
        end else begin
            wrStrobe <= 1'b0;
            loadPending_reg <= 1'b0;
            if (enN) begin
                phase_reg <= TXFE_IDLE;
                bitCnt_reg <= 5'h00;
                isRead_reg <= 1'b0;
            end else begin
                case (phase_reg)
                    TXFE_IDLE: begin
                        phase_reg <= TXFE_HEADER;
                    end
                    TXFE_HEADER: begin
                        if (rise) begin
                            shiftIn_reg <= {shiftIn_reg[14:0], din};
                            bitCnt_reg <= bitCnt_reg + 5'h01;
                            if (bitCnt_reg == `TXFE_HDR_LAST) begin
                                phase_reg <= TXFE_DATA;
                                isRead_reg <= shiftIn_reg[6];
                                loadPending_reg <= shiftIn_reg[6];
                                regAddr <= {shiftIn_reg[3:0], din};
                            end
                        end
                    end
                    TXFE_DATA: begin
                        if (rise && bitCnt_reg != `TXFE_FRAME_BITS) begin
                            shiftIn_reg <= {shiftIn_reg[14:0], din};
                            bitCnt_reg <= bitCnt_reg + 5'h01;
                            // a write takes effect only once all 16 bits are in
                            if (bitCnt_reg == `TXFE_FRAME_LAST && !isRead_reg) begin
                                wrData <= {shiftIn_reg[14:0], din};
                                wrStrobe <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        phase_reg <= TXFE_IDLE;
                    end
                endcase
            end
        end
    end

    // read data changes on falling serial clock so the master samples on rising
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            serDataOut <= 1'b0;
            serDataOe <= 1'b0;
            shiftOut_reg <= 15'h0000;
        end else if (enN) begin
            serDataOut <= 1'b0;
            serDataOe <= 1'b0;
        end else if (loadPending_reg) begin
            serDataOut <= rdData[15];
            shiftOut_reg <= rdData[14:0];
            serDataOe <= 1'b1;
        end else if (fall && serDataOe && bitCnt_reg > `TXFE_HDR_BITS) begin
            serDataOut <= shiftOut_reg[14];
            shiftOut_reg <= {shiftOut_reg[13:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// ===== dv/txfe_checker.sv
// port-level concurrent checks for the transmit front-end control block
`default_nettype none
module txfe_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic serEnableN,
    input wire logic serDataOe,
    input wire logic txActive,
    input wire logic generalOutPin,
    input wire logic extAmpEnableOut,
    input wire logic [5:0] extAmpLevelDac,
    input wire logic [2:0] intAmpBiasSelect
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [3:0] idleCnt;
    // a write lands several cycles after its frame, so wait out a settled gap
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            idleCnt <= 4'h0;
        else if (!serEnableN)
            idleCnt <= 4'h0;
        else if (idleCnt != 4'hF)
            idleCnt <= idleCnt + 4'h1;
    end
    wire logic quiet = idleCnt > 4'h8;
    reset_zero_a: assert property ($rose(rstn) |->
        {generalOutPin, extAmpEnableOut, extAmpLevelDac} == 8'h00)
        else $error("outputs not clear after reset");
    dac_gate_a: assert property (!txActive |=>
        extAmpLevelDac == 6'h00) else $error("level code not gated");
    gen_steady_a: assert property (quiet |=>
        $stable(generalOutPin)) else $error("output pin moved unwritten");
    bias_steady_a: assert property (quiet |=>
        $stable(intAmpBiasSelect)) else $error("bias moved unwritten");
    dac_steady_a: assert property (quiet && $stable(txActive) |=>
        $stable(extAmpLevelDac)) else $error("level code glitch");
    amp_steady_a: assert property (quiet && $stable(txActive) |=>
        $stable(extAmpEnableOut)) else $error("amp enable glitch");
    amp_pair_a: assert property (quiet && !txActive |=>
        !(extAmpEnableOut && generalOutPin)) else $error("amp pair wrong");
    oe_idle_a: assert property (serEnableN [*6] |=> !serDataOe)
        else $error("data pin driven outside frame");
endmodule
bind txfe_control txfe_checker chk (.sys_clk(sys_clk), .rstn(rstn),
    .serEnableN(serEnableN), .serDataOe(serDataOe), .txActive(txActive),
    .generalOutPin(generalOutPin), .extAmpEnableOut(extAmpEnableOut),
    .extAmpLevelDac(extAmpLevelDac), .intAmpBiasSelect(intAmpBiasSelect));
`default_nettype wire

// ===== dv/txfe_front_model.sv
// antenna switch and external amplifier driven by the control pins
`default_nettype none
module txfe_front_model #(
    parameter int WARM = 20
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic generalOutPin,
    input wire logic extAmpEnableOut,
    output logic switchTx,
    output logic ampFull
);
    timeunit 1ns;
    timeprecision 1ns;
    int warmCnt;
    assign switchTx = generalOutPin;
    // full power well inside 50 cycles of enable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            warmCnt <= 0;
        else if (!extAmpEnableOut)
            warmCnt <= 0;
        else if (warmCnt < WARM)
            warmCnt <= warmCnt + 1;
    end
    assign ampFull = warmCnt >= WARM;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the transmit front-end control block
`default_nettype none
`include "txfe_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] r2;
        logic [15:0] r3;
        logic [15:0] r11;
        logic tx;
        logic [7:0] q;
    } txfe_row_t;
    localparam logic [3:0] VER = 4'hA; // arbitrary value
    localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
    localparam logic [6:0] MAKER = 7'h35; // arbitrary value
`define CHK(n, e, s) \
    compares++; \
    if ((s) !== (e)) begin \
        num_errors++; \
        $display("MISMATCH %s exp %h got %h", n, e, s); \
    end
    logic sys_clk = 1'b0, rstn = 1'b0, serEnableN = 1'b1, serClk = 1'b0;
    logic hostData = 1'b0, txActive = 1'b0, serDataOut, serDataOe;
    logic generalOutPin, extAmpEnableOut, switchTx, ampFull;
    logic [5:0] extAmpLevelDac;
    logic [2:0] intAmpBiasSelect;
    logic [15:0] q, idLow;
    int num_errors = 0, compares = 0;
    // shared data pin: the device wins while it drives
    wire logic serDataWire = serDataOe ? serDataOut : hostData;
    wire logic [10:0] pins = {generalOutPin, extAmpEnableOut,
        extAmpLevelDac, intAmpBiasSelect};
    txfe_row_t rows [8] = '{
        '{16'h0100, 16'h0000, 16'h0000, 1'b1, 8'h80},
        '{16'h0000, 16'h0040, 16'h0000, 1'b0, 8'h80},
        '{16'h0100, 16'h0040, 16'h0000, 1'b1, 8'h00},
        '{16'h0100, 16'h0400, 16'h0000, 1'b0, 8'h80},
        '{16'h0000, 16'h0400, 16'h0000, 1'b0, 8'h40},
        '{16'h0000, 16'h045F, 16'h0040, 1'b1, 8'h80},
        '{16'h0000, 16'h003F, 16'h00C0, 1'b1, 8'h7F},
        '{16'h0000, 16'h0015, 16'h00C0, 1'b0, 8'h00}};
    txfe_control #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .serEnableN(serEnableN),
        .serClk(serClk), .serDataIn(serDataWire), .serDataOut(serDataOut),
        .serDataOe(serDataOe), .txActive(txActive),
        .generalOutPin(generalOutPin), .extAmpEnableOut(extAmpEnableOut),
        .extAmpLevelDac(extAmpLevelDac), .intAmpBiasSelect(intAmpBiasSelect));
    txfe_front_model model (.sys_clk(sys_clk), .rstn(rstn),
        .generalOutPin(generalOutPin), .extAmpEnableOut(extAmpEnableOut),
        .switchTx(switchTx), .ampFull(ampFull));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // serial clock phases of 5 cycles low and 6 high keep well above the 4-cycle minimum
    task automatic xfer(input logic rd, input logic [4:0] a,
            input logic [15:0] d, output logic [15:0] r);
        logic [23:0] f;
        f = {rd, 2'b00, a, d};
        serEnableN <= 1'b0;
        repeat (5) @(posedge sys_clk);
        for (int i = 23; i >= 0; i--) begin
            hostData <= f[i];
            repeat (5) @(posedge sys_clk);
            serClk <= 1'b1;
            repeat (5) @(posedge sys_clk);
            #1 if (i < 16) r[i] = serDataWire;
            @(posedge sys_clk);
            serClk <= 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        serEnableN <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        `CHK("reset pins", 11'h000, pins)
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            txActive <= 1'b0;
            xfer(1'b0, `TXFE_ADDR_CTRL2, rows[i].r2, q);
            xfer(1'b0, `TXFE_ADDR_CTRL3, rows[i].r3, q);
            xfer(1'b0, `TXFE_ADDR_CTRL11, rows[i].r11, q);
            xfer(1'b0, `TXFE_ADDR_CTRL5, 16'(i), q);
            txActive <= rows[i].tx;
            repeat (25) @(posedge sys_clk);
            `CHK("pins", rows[i].q, pins[10:3])
            `CHK("bias", i[2:0], intAmpBiasSelect)
            `CHK("amp power", rows[i].q[6], ampFull)
        end
        xfer(1'b0, `TXFE_ADDR_CTRL3, 16'hFFFF, q);
        xfer(1'b1, `TXFE_ADDR_CTRL3, 16'h0000, q);
        `CHK("ctrl3 read", 16'h047F, q)
        xfer(1'b1, `TXFE_ADDR_CTRL5, 16'h0000, q);
        `CHK("ctrl5 read", 16'h0007, q)
        xfer(1'b1, `TXFE_ADDR_CTRL11, 16'h0000, q);
        `CHK("ctrl11 read", 16'h00C0, q)
        // switch must already sit in transmit before the cycle starts
        `CHK("switch", 1'b1, switchTx)
        txActive <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("full scale", 8'hBF, pins[10:3])
        txActive <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK("gated dac", 6'h00, extAmpLevelDac)
        xfer(1'b0, `TXFE_ADDR_CTRL2, 16'hFFFF, q);
        xfer(1'b1, `TXFE_ADDR_CTRL2, 16'h0000, q);
        `CHK("ctrl2 read", 16'h0100, q)
        `CHK("inverted pair", 8'h40, pins[10:3])
        xfer(1'b0, `TXFE_ADDR_ID_LOW, 16'h0000, q);
        xfer(1'b1, `TXFE_ADDR_ID_LOW, 16'h0000, idLow);
        xfer(1'b1, `TXFE_ADDR_ID_HIGH, 16'h0000, q);
        `CHK("id", {VER, PART, 4'h0, MAKER, 1'b1}, {q, idLow})
        xfer(1'b1, 5'h07, 16'h0000, q);
        `CHK("unmapped", 16'h0000, q)
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK("reset pins", 11'h000, pins)
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK("cleared pins", 11'h000, pins)
        stop_test();
    end
endmodule
`default_nettype wire
